// ### lphp_defs.svh
// Timing counts and encodings for the parallel display host port.
// Assumes a 20 MHz system clock; included by bare name.
`ifndef LPHP_DEFS_SVH
`define LPHP_DEFS_SVH

`define LPHP_CLK_NS 50
// Least phase times in ns, each rounded up to whole cycles
`define LPHP_SETUP_NS 50
`define LPHP_STROBE_LOW_NS 100
`define LPHP_STROBE_HIGH_NS 50
`define LPHP_CYC(ns) (((ns) + `LPHP_CLK_NS - 1) / `LPHP_CLK_NS)
`define LPHP_SETUP_CYC `LPHP_CYC(`LPHP_SETUP_NS)
`define LPHP_LOW_CYC `LPHP_CYC(`LPHP_STROBE_LOW_NS)
`define LPHP_HIGH_CYC `LPHP_CYC(`LPHP_STROBE_HIGH_NS)
// Reset pulse and recovery in ns
`define LPHP_RST_LOW_NS 10000
`define LPHP_RST_WAIT_NS 120000000
// Select line encoding
`define LPHP_DC_COMMAND 1'h0
`define LPHP_DC_DATA 1'h1
`define LPHP_DATA_W 16
`define LPHP_FIFO_DEPTH 4

`endif

// ### lphp_fifo.sv
// Small synchronous FIFO for outgoing bus words.
// Assumes one clock, synchronous reset and a clock enable that freezes it.
`timescale 1ns/1ps
module lphp_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 4
) (
    // Clock and control
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    ////////////////////////////////////////////////////////////////////////
    // Handshakes are combinational; full and empty come from the count
    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rp_reg]; // Entry itself is a register
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer arithmetic wraps at DEPTH
    always_comb
    begin
        wp_next = wp_reg;
        rp_next = rp_reg;
        cnt_next = cnt_reg;
        if (push)
        begin
            wp_next = (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
        end
        if (pop)
        begin
            rp_next = (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
        end
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Registers only
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end
        else if (ce)
        begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    // Storage has no reset; contents are invisible while empty
    always_ff @(posedge clk)
    begin
        if (ce && push)
        begin
            mem_reg[wp_reg] <= in_data;
        end
    end
endmodule : lphp_fifo

// ### lphp_host.sv
// Host-side driver of the 16-bit parallel display strobe bus.
// Assumes the display samples its write strobe rising edge and that its
// pins are wired directly; the data pins are two-way, split three ways.
`timescale 1ns/1ps
`include "lphp_defs.svh"
module lphp_host
    import lphp_pkg::*;
#(
    parameter int DATA_W = `LPHP_DATA_W,
    parameter int DEPTH = `LPHP_FIFO_DEPTH,
    parameter int RST_LOW_CYC = (`LPHP_RST_LOW_NS + `LPHP_CLK_NS - 1) / `LPHP_CLK_NS,
    parameter int RST_WAIT_CYC = (`LPHP_RST_WAIT_NS + `LPHP_CLK_NS - 1) / `LPHP_CLK_NS,
    parameter int PWM_W = 8
) (
    // Clock and control
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // Write requests: is_data high for data or parameter, low for command
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic wr_is_data,
    input wire logic [DATA_W-1:0] wr_word,
    // Read requests and answer
    input wire logic rd_req,
    output logic rd_ready,
    output logic rd_valid,
    output logic [DATA_W-1:0] rd_word,
    // Status and backlight level
    output logic init_done,
    input wire logic [PWM_W-1:0] backlight_level,
    // Display pins
    output logic chip_select_n,
    output logic reset_n,
    output logic data_command_sel,
    output logic store_strobe_n,
    output logic read_strobe_n,
    output logic backlight_on,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe
);
    localparam int CW = 32;
    lphp_state_t st_reg, st_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic cs_reg, cs_next, res_reg, res_next, dc_reg, dc_next;
    logic wr_reg, wr_next, rd_reg, rd_next, oe_reg, oe_next;
    logic [DATA_W-1:0] dout_reg, dout_next, rdw_reg, rdw_next;
    logic rdv_reg, rdv_next, done_reg, done_next;
    logic [PWM_W-1:0] pwm_reg, pwm_next;
    logic bl_reg, bl_next;
    logic f_valid, f_pop;
    logic [DATA_W:0] f_data;

    // Reload a phase counter, never below one cycle
    function automatic logic [CW-1:0] lphp_load(input int cyc);
        lphp_load = (cyc < 1) ? CW'(0) : CW'(cyc - 1);
    endfunction : lphp_load

    ////////////////////////////////////////////////////////////////////////
    // Outgoing words queue here so the user side sees back-pressure
    // sixteen-bit words carried whole with their select bit
    lphp_fifo #(.WIDTH(DATA_W + 1), .DEPTH(DEPTH)) u_fifo (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .in_valid(wr_valid && done_reg),
        .in_ready(wr_ready),
        .in_data({wr_is_data, wr_word}),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data)
    );
    // Pop as chip select falls and the setup phase starts
    assign f_pop = (st_reg == LPHP_IDLE) && f_valid;
    // Reads wait behind queued writes, keeping command order
    assign rd_ready = (st_reg == LPHP_IDLE) && !f_valid;

    ////////////////////////////////////////////////////////////////////////
    // Bus sequencer
    always_comb
    begin
        st_next = st_reg;
        cnt_next = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
        cs_next = cs_reg;
        res_next = res_reg;
        dc_next = dc_reg;
        wr_next = wr_reg;
        rd_next = rd_reg;
        oe_next = oe_reg;
        dout_next = dout_reg;
        rdw_next = rdw_reg;
        rdv_next = 1'b0;
        done_next = done_reg;
        unique case (st_reg)
            // hold display reset low, then wait for recovery
            LPHP_RST_LOW:
                if (cnt_reg == '0)
                begin
                    res_next = 1'b1;
                    cnt_next = lphp_load(RST_WAIT_CYC);
                    st_next = LPHP_RST_WAIT;
                end
            LPHP_RST_WAIT:
                if (cnt_reg == '0)
                begin
                    done_next = 1'b1;
                    st_next = LPHP_IDLE;
                end
            LPHP_IDLE:
                if (f_valid)
                begin
                    // select set and chip select low with data
                    dc_next = f_data[DATA_W];
                    cs_next = 1'b0;
                    dout_next = f_data[DATA_W-1:0];
                    oe_next = 1'b1;
                    cnt_next = lphp_load(`LPHP_SETUP_CYC);
                    st_next = LPHP_SETUP;
                end
                else if (rd_req)
                begin
                    // chip select low first, bus released
                    cs_next = 1'b0;
                    oe_next = 1'b0;
                    cnt_next = lphp_load(`LPHP_SETUP_CYC);
                    st_next = LPHP_RD_SEL;
                end
            LPHP_SETUP:
                if (cnt_reg == '0)
                begin
                    wr_next = 1'b0;
                    cnt_next = lphp_load(`LPHP_LOW_CYC);
                    st_next = LPHP_WR_LOW;
                end
            LPHP_WR_LOW:
                if (cnt_reg == '0)
                begin
                    wr_next = 1'b1;
                    cnt_next = lphp_load(`LPHP_HIGH_CYC);
                    st_next = LPHP_WR_HIGH;
                end
            LPHP_WR_HIGH:
                if (cnt_reg == '0)
                begin
                    cs_next = 1'b1;
                    cnt_next = lphp_load(`LPHP_HIGH_CYC);
                    st_next = LPHP_DESEL;
                end
            LPHP_RD_SEL:
                if (cnt_reg == '0 && dc_reg != `LPHP_DC_DATA)
                begin
                    // select rises a phase after chip select
                    dc_next = `LPHP_DC_DATA;
                    cnt_next = lphp_load(`LPHP_SETUP_CYC);
                end
                else if (cnt_reg == '0)
                begin
                    // read strobe falls once select is high
                    rd_next = 1'b0;
                    cnt_next = lphp_load(`LPHP_LOW_CYC);
                    st_next = LPHP_RD_LOW;
                end
            LPHP_RD_LOW:
                if (cnt_reg == '0)
                begin
                    // sample the bus as the strobe rises
                    rd_next = 1'b1;
                    rdw_next = data_in;
                    rdv_next = 1'b1;
                    cnt_next = lphp_load(`LPHP_HIGH_CYC);
                    st_next = LPHP_RD_HIGH;
                end
            LPHP_RD_HIGH:
                if (cnt_reg == '0)
                begin
                    // chip select rise ends the read
                    cs_next = 1'b1;
                    cnt_next = lphp_load(`LPHP_HIGH_CYC);
                    st_next = LPHP_DESEL;
                end
            LPHP_DESEL:
                // idle gap of LPHP_HIGH_CYC cycles, then back to idle
                if (cnt_reg == '0)
                begin
                    st_next = LPHP_IDLE;
                end
            default:
                st_next = LPHP_IDLE;
        endcase
    end

    // Sequencer registers; reset parks all strobes inactive
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_reg <= LPHP_RST_LOW;
            cnt_reg <= CW'(RST_LOW_CYC > 0 ? RST_LOW_CYC - 1 : 0);
            cs_reg <= 1'b1;
            res_reg <= 1'b0;
            dc_reg <= `LPHP_DC_COMMAND;
            wr_reg <= 1'b1;
            rd_reg <= 1'b1;
            oe_reg <= 1'b0;
            dout_reg <= '0;
            rdw_reg <= '0;
            rdv_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else if (ce)
        begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            cs_reg <= cs_next;
            res_reg <= res_next;
            dc_reg <= dc_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            oe_reg <= oe_next;
            dout_reg <= dout_next;
            rdw_reg <= rdw_next;
            rdv_reg <= rdv_next;
            done_reg <= done_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Backlight PWM: level 0 off, all ones always on
    always_comb
    begin
        pwm_next = pwm_reg + 1'b1;
        bl_next = (pwm_reg < backlight_level) || (&backlight_level);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pwm_reg <= '0;
            bl_reg <= 1'b0;
        end
        else if (ce)
        begin
            pwm_reg <= pwm_next;
            bl_reg <= bl_next;
        end
    end

    // Pins and answers all come straight from flip-flops
    assign chip_select_n = cs_reg;
    assign reset_n = res_reg;
    assign data_command_sel = dc_reg;
    assign store_strobe_n = wr_reg;
    assign read_strobe_n = rd_reg;
    assign data_out = dout_reg;
    assign data_oe = oe_reg;
    assign backlight_on = bl_reg;
    assign rd_word = rdw_reg;
    assign rd_valid = rdv_reg;
    assign init_done = done_reg;
endmodule : lphp_host

// ### lphp_host_sva.sv
// Pin sequence checks for the display host port.
// Assumes a bind onto lphp_host; checks are disabled while ce is low.
`timescale 1ns/1ps
module lphp_host_sva #(
    parameter int DATA_W = 16
) (
    // Clock and control
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    // User side
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire logic init_done,
    // Display pins
    input wire logic chip_select_n,
    input wire logic data_command_sel,
    input wire logic store_strobe_n,
    input wire logic read_strobe_n,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic data_oe
);
////////////////////////////////////////////////
    // A frozen clock enable aborts attempts rather than stretching them
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst || !ce);
    property p_wr_sel; !store_strobe_n |-> !chip_select_n && data_oe; endproperty
    a_wr_sel: assert property (p_wr_sel)
        else $error("write strobe outside select");
    property p_rd_pins;
        !read_strobe_n |-> !chip_select_n && data_command_sel && !data_oe;
    endproperty
    a_rd_pins: assert property (p_rd_pins)
        else $error("read strobe with bad pins");
    property p_rd_setup;
        $fell(read_strobe_n) |-> $past(data_command_sel) && !$past(chip_select_n);
    endproperty
    a_rd_setup: assert property (p_rd_setup)
        else $error("read strobe fell without setup");
    property p_wr_setup;
        $fell(store_strobe_n) |-> $past(chip_select_n) == 1'b0 && $past(data_oe);
    endproperty
    a_wr_setup: assert property (p_wr_setup)
        else $error("strobe fell without setup");
    property p_wr_pulse; $fell(store_strobe_n) |=> !store_strobe_n ##1 store_strobe_n; endproperty
    a_wr_pulse: assert property (p_wr_pulse)
        else $error("write strobe width wrong");
    property p_wr_end; $rose(store_strobe_n) |-> !chip_select_n ##1 chip_select_n; endproperty
    a_wr_end: assert property (p_wr_end)
        else $error("select not ended after write");
    property p_rd_end; $rose(read_strobe_n) |-> !chip_select_n ##1 chip_select_n; endproperty
    a_rd_end: assert property (p_rd_end)
        else $error("select not ended after read");
    property p_wr_hold;
        !store_strobe_n |-> $stable(data_out) && $stable(data_command_sel);
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("bus moved under strobe");
    property p_wr_go; wr_valid && wr_ready && init_done |-> ##[1:30] $fell(store_strobe_n); endproperty
    a_wr_go: assert property (p_wr_go)
        else $error("accepted word never strobed");
    // Main scenarios
    c_wr: cover property ($rose(store_strobe_n));
    c_rd: cover property ($rose(read_strobe_n));
    c_full: cover property (wr_valid && !wr_ready && init_done);
endmodule : lphp_host_sva

// ### lphp_panel_model.sv
// Behavioural display panel on the far side of the host port.
// Assumes the bench resolves the shared bus from the host enable.
`timescale 1ns/1ps
module lphp_panel_model (
    // Pins from the host
    input wire logic chip_select_n,
    input wire logic reset_n,
    input wire logic data_command_sel,
    input wire logic store_strobe_n,
    input wire logic read_strobe_n,
    input wire logic [15:0] bus,
    // Bench value and panel drive
    input wire logic [15:0] read_value,
    output logic [15:0] drive
);
////////////////////////////////////////////////
    // log stands for frame memory, address advancing per word
    logic [16:0] log_mem [0:15];
    int n_log = 0;
    int n_bad = 0;
    // capture select and 16-bit word on strobe rise
    // deselected strobes are ignored; selected ones in reset or past 16 words count as bad
    always @(posedge store_strobe_n)
    begin
        if (chip_select_n === 1'b0 && reset_n === 1'b1 && n_log < 16)
        begin
            log_mem[n_log] = {data_command_sel, bus};
            n_log++;
        end
        else if (chip_select_n === 1'b0)
            n_bad++;
    end
    // drive only while read strobe low; released bus shows inverse
    assign drive = (chip_select_n === 1'b0 && read_strobe_n === 1'b0) ? read_value : ~read_value;
endmodule : lphp_panel_model

// ### lphp_pkg.sv
// Types for the parallel display host port.
// Assumes lphp_defs.svh is compiled alongside.
package lphp_pkg;
    typedef enum logic [3:0] {
        LPHP_RST_LOW = 4'h0,
        LPHP_RST_WAIT = 4'h1,
        LPHP_IDLE = 4'h2,
        LPHP_SETUP = 4'h3,
        LPHP_WR_LOW = 4'h4,
        LPHP_WR_HIGH = 4'h5,
        LPHP_RD_SEL = 4'h6,
        LPHP_RD_LOW = 4'h7,
        LPHP_RD_HIGH = 4'h8,
        LPHP_DESEL = 4'h9
    } lphp_state_t;
endpackage : lphp_pkg

// ### testbench.sv
// Self-checking bench for the display host port with a panel model.
// Assumes short reset counts; inputs change on falling clock edges.
`timescale 1ns/1ps
module testbench;
    logic clk, srst, ce, wr_valid, wr_ready, wr_is_data, rd_req, rd_ready, rd_valid;
    logic init_done, chip_select_n, reset_n, data_command_sel, store_strobe_n;
    logic read_strobe_n, backlight_on, data_oe, full_seen;
    logic [15:0] wr_word, rd_word, data_out, bus, drive;
    logic [7:0] backlight_level;
    int n_fail = 0;
    int checks = 0;
    // Shared bus: host when enabled, else panel
    assign bus = data_oe ? data_out : drive;
    lphp_host #(.RST_LOW_CYC(3), .RST_WAIT_CYC(5)) dut (.clk(clk), .srst(srst), .ce(ce),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_is_data(wr_is_data), .wr_word(wr_word),
        .rd_req(rd_req), .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_word(rd_word),
        .init_done(init_done), .backlight_level(backlight_level),
        .chip_select_n(chip_select_n), .reset_n(reset_n), .data_command_sel(data_command_sel),
        .store_strobe_n(store_strobe_n), .read_strobe_n(read_strobe_n),
        .backlight_on(backlight_on), .data_in(bus), .data_out(data_out), .data_oe(data_oe));
    lphp_panel_model panel (.chip_select_n(chip_select_n), .reset_n(reset_n),
        .data_command_sel(data_command_sel), .store_strobe_n(store_strobe_n),
        .read_strobe_n(read_strobe_n), .bus(bus), .read_value(16'hA5C3), .drive(drive));
////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
        checks++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
            n_fail++;
        end
    endtask : check
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    // Queue one word; holds valid until taken, a full FIFO is noted
    task automatic push(input logic dc, input logic [15:0] w);
        int n = 0;
        wr_valid = 1'b1;
        wr_is_data = dc;
        wr_word = w;
        while (wr_ready !== 1'b1 && n < 100)
        begin
            full_seen = 1'b1;
            @(negedge clk);
            n++;
        end
        @(negedge clk);
    endtask : push
    task automatic t_reset;
        int low = 0;
        int n = 0;
        repeat (5) @(negedge clk);
        srst = 1'b0;
        check("rst_pins", {reset_n, chip_select_n, init_done}, 17'h2);
        while (reset_n !== 1'b1 && low < 50)
        begin
            @(negedge clk);
            low++;
        end
        check("rst_low", low >= 3, 17'h1);
        while (init_done !== 1'b1 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        check("init", init_done, 17'h1);
        $display("reset test done");
    endtask : t_reset
    // Window command, then RGB565 pixels, sent back to back into a full FIFO
    task automatic t_write;
        logic [16:0] exp [0:7] = '{17'h0002A, 17'h10000, 17'h1001F, 17'h0002C,
            17'h1F800, 17'h107E0, 17'h1001F, 17'h1FFFF};
        int n = 0;
        foreach (exp[i]) push(exp[i][16], exp[i][15:0]);
        wr_valid = 1'b0;
        while (panel.n_log < 8 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        check("full", full_seen, 17'h1);
        foreach (exp[i]) check("word", panel.log_mem[i], exp[i]);
        check("bad", panel.n_bad == 0, 17'h1);
        $display("write test done");
    endtask : t_write
    // Read right behind a command: waits for it, then raises the select line
    task automatic t_read;
        int n = 0;
        push(1'b0, 16'hABCD);
        wr_valid = 1'b0;
        check("rd_busy", rd_ready, 17'h0);
        while (rd_ready !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        rd_req = 1'b1;
        @(negedge clk);
        rd_req = 1'b0;
        n = 0;
        while (rd_valid !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        check("rd_word", rd_word, 17'h0A5C3);
        check("rd_order", panel.log_mem[8], 17'h0ABCD);
        $display("read test done");
    endtask : t_read
    // Clock enable low under a write strobe freezes the pins; the word then completes
    task automatic t_freeze;
        int n = 0;
        push(1'b1, 16'h1234);
        wr_valid = 1'b0;
        while (store_strobe_n !== 1'b0 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        ce = 1'b0;
        repeat (10) @(negedge clk);
        check("frz_pins", {chip_select_n, store_strobe_n, data_oe}, 17'h1);
        check("frz_log", 17'(panel.n_log), 17'h9);
        ce = 1'b1;
        n = 0;
        while (panel.n_log < 10 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        check("frz_word", panel.log_mem[9], 17'h11234);
        $display("freeze test done");
    endtask : t_freeze
    // High cycles counted over one whole PWM period of 256 cycles
    task automatic t_light(input logic [7:0] lvl, input int exp);
        int hit = 0;
        backlight_level = lvl;
        repeat (3) @(negedge clk);
        repeat (256)
        begin
            @(negedge clk);
            if (backlight_on === 1'b1)
                hit++;
        end
        check("light", 17'(hit), 17'(exp));
        $display("backlight test done");
    endtask : t_light
    initial
    begin
        srst = 1'b1;
        ce = 1'b1;
        wr_valid = 1'b0;
        wr_is_data = 1'b0;
        wr_word = 16'h0000;
        rd_req = 1'b0;
        backlight_level = 8'h00;
        full_seen = 1'b0;
        t_reset;
        t_write;
        t_read;
        t_freeze;
        t_light(8'h00, 0);
        t_light(8'h80, 128);
        t_light(8'hFF, 256);
        complete_run;
    end
    // Whole run needs about 900 cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        complete_run;
    end
endmodule : testbench
bind lphp_host lphp_host_sva #(.DATA_W(DATA_W)) u_sva (.clk(clk), .srst(srst), .ce(ce),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .init_done(init_done),
    .chip_select_n(chip_select_n), .data_command_sel(data_command_sel),
    .store_strobe_n(store_strobe_n), .read_strobe_n(read_strobe_n),
    .data_out(data_out), .data_oe(data_oe));
